// File: core/ltet_link_if.sv
// Trigger and line timing link between source and sensor
`timescale 1ns/10ps
interface ltet_link_if;
	logic trig_cl;
	logic trig_ttl;
	logic line_start;
	logic accum_ch1;
	logic accum_ch2;

	modport dev_mp (
		input  trig_cl,
		input  trig_ttl,
		output line_start,
		output accum_ch1,
		output accum_ch2
	);
	modport src_mp (
		output trig_cl,
		output trig_ttl,
		input  line_start,
		input  accum_ch1,
		input  accum_ch2
	);
endinterface

// File: core/ltet_pkg.sv
// Shared constants and types for line trigger and exposure timing
// Behaviour
// - Exposure and trigger mode commands select behaviour
// - External off mode: exposure is period minus overhead
// - Source never triggers faster than 25.48 us
// - Source keeps trigger period 25.48 us to 2 ms; ltet_source enforces only the lower bound
// - Off mode disables shutter; balancing adjusts gain only
// - Trigger pulse minimum 20.48 us link, 50 us TTL
// - Timed mode: trigger spacing exposure plus 5.1 us
// - Timed shutter programmable 20.38 us to 1.995 ms
// - Timed mode: separate shutter per channel
// - Shutter steps one sensor clock, per channel
// - Pulse mode accumulates while trigger active, spaced triggers
// - Pulse mode widths within documented per-input ranges
// - Source keeps triggering during channel balancing
// - Internal line period 25.48 us to 2 ms
// - Internal off mode: exposure is period minus overhead
// - Internal timed: shutter limited to period minus overhead
// - Sensor clock 149.92 ns, pixel clock eight times faster
// - Receiver discards first line and after long gaps
package ltet_pkg;
	// ****************************************
	// Clock and time figures
	// ****************************************
	localparam int CLK_PS        = 5_000;
	localparam int T_SPCLK_PS    = 149_920;
	localparam int SPCLK_DIV     = (T_SPCLK_PS + CLK_PS / 2) / CLK_PS;
	localparam int PCLK_MULT     = 8;
	localparam int T_OVH_NS      = 5_100;
	localparam int T_MIN_EXP_NS  = 20_380;
	localparam int T_MIN_PER_NS  = 25_480;
	localparam int T_MAX_SH_NS   = 1_995_000;
	localparam int T_MAX_PER_NS  = 2_000_000;
	localparam int T_CL_MIN_NS   = 20_480;
	localparam int T_TTL_MIN_NS  = 50_000;
	localparam int T_GAP_NS      = 2_000_000;

	// ****************************************
	// Counts in sensor clocks and in clk cycles
	// ****************************************
	localparam int SP_W = 14;
	localparam logic [SP_W-1:0] OVH_SP =
		SP_W'((T_OVH_NS * 1000 + T_SPCLK_PS - 1) / T_SPCLK_PS);
	localparam logic [SP_W-1:0] MIN_EXP_SP =
		SP_W'((T_MIN_EXP_NS * 1000 + T_SPCLK_PS - 1) / T_SPCLK_PS);
	localparam logic [SP_W-1:0] MIN_PER_SP =
		SP_W'((T_MIN_PER_NS * 1000 + T_SPCLK_PS - 1) / T_SPCLK_PS);
	localparam logic [SP_W-1:0] MAX_SH_SP =
		SP_W'(T_MAX_SH_NS * 1000 / T_SPCLK_PS);
	localparam logic [SP_W-1:0] MAX_PER_SP =
		SP_W'(T_MAX_PER_NS * 1000 / T_SPCLK_PS);
	localparam int CL_MIN_CYC  = (T_CL_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TTL_MIN_CYC = (T_TTL_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int MIN_PER_CYC = (T_MIN_PER_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int MAX_SH_CYC  = T_MAX_SH_NS * 1000 / CLK_PS;
	localparam int OVH_CYC     = (T_OVH_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int GAP_CYC     = (T_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int SPD_W = 5;
	localparam int WID_W = 14;
	localparam int HC_W  = 20;

	// ****************************************
	// Mode commands
	// ****************************************
	localparam logic [1:0] EXP_OFF   = 2'h0;
	localparam logic [1:0] EXP_TIMED = 2'h1;
	localparam logic [1:0] EXP_PULSE = 2'h2;

	// ****************************************
	// Source register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h04;
	localparam logic [ADDR_W-1:0] REG_WIDTH  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_EXPO   = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_TTL   = 1;
	localparam int CTRL_PULSE = 2;
	localparam int STAT_DISC  = 0;
	localparam int STAT_RUN   = 1;
	localparam int LCNT_W     = 16;
	localparam int LCNT_LSB   = 16;

	typedef enum {LTET_IDLE, LTET_HIGH, LTET_LOW} ltet_gen_t;
endpackage

// File: core/ltet_sensor.sv
// Sensor end: line start and per-channel exposure timing
`timescale 1ns/10ps
module ltet_sensor #(
	parameter int TTL_MIN_CYC = ltet_pkg::TTL_MIN_CYC
) (
	input  wire logic                      clk_in,
	input  wire logic                      rst_n_in,
	ltet_link_if.dev_mp                    link,
	input  wire logic [1:0]                exp_mode_command_in,
	input  wire logic                      trigger_mode_command_in,
	input  wire logic                      trig_ttl_sel_in,
	input  wire logic [ltet_pkg::SP_W-1:0] line_period_in,
	input  wire logic [ltet_pkg::SP_W-1:0] shutter_ch1_in,
	input  wire logic [ltet_pkg::SP_W-1:0] shutter_ch2_in,
	output logic                           line_start_out,
	output logic                           accum_ch1_out,
	output logic                           accum_ch2_out,
	output logic                           spclk_out,
	output logic                           pclk_stb_out,
	output logic                           shutter_en_out,
	output logic                           balance_gain_only_out,
	output logic                           trig_reject_out,
	output logic                           trig_short_out
);
	localparam int W = ltet_pkg::SP_W;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [1:0]                  cl_sync;
		logic [1:0]                  ttl_sync;
		logic                        trig_d;
		logic [ltet_pkg::SPD_W-1:0]  div;
		logic [ltet_pkg::SPD_W-1:0]  frac;
		logic                        spclk;
		logic                        pclk;
		logic [ltet_pkg::WID_W-1:0]  wid;
		logic [W-1:0]                per;
		logic [W-1:0]                meas;
		logic [W-1:0]                acc;
		logic                        acc1;
		logic                        acc2;
		logic                        pw_run;
		logic                        first;
		logic                        line;
		logic                        reject;
		logic                        short_p;
	} ltet_dev_state_t;

	ltet_dev_state_t state_reg;
	ltet_dev_state_t state_next;

	function automatic logic [W-1:0] ltet_clamp(
		input logic [W-1:0] v,
		input logic [W-1:0] lo,
		input logic [W-1:0] hi
	);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction

	function automatic logic [W-1:0] ltet_sub(
		input logic [W-1:0] a,
		input logic [W-1:0] b
	);
		return (a > b) ? a - b : '0;
	endfunction

	logic                       trig;
	logic                       tick;
	logic                       ext;
	logic                       pulse_width_exposure_mode;
	logic                       qualify;
	logic                       fall;
	logic                       start;
	logic [ltet_pkg::WID_W-1:0] min_w;
	logic [W-1:0]               period;
	logic [W-1:0]               lim;
	logic [W-1:0]               off_t;
	logic [W-1:0]               tgt1;
	logic [W-1:0]               tgt2;
	logic [ltet_pkg::SPD_W:0]   fsum;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		state_next.cl_sync = {state_reg.cl_sync[0], link.trig_cl};
		state_next.ttl_sync = {state_reg.ttl_sync[0], link.trig_ttl};
		trig = trig_ttl_sel_in ? state_reg.ttl_sync[1]
			: state_reg.cl_sync[1];
		state_next.trig_d = trig;
		// Sensor clock divider and 8x pixel strobe
		tick = state_reg.div == ltet_pkg::SPD_W'(ltet_pkg::SPCLK_DIV - 1);
		state_next.div = tick ? '0 : state_reg.div + 1'b1;
		state_next.spclk = state_reg.div <
			ltet_pkg::SPD_W'(ltet_pkg::SPCLK_DIV / 2);
		fsum = {1'b0, state_reg.frac} + (ltet_pkg::SPD_W + 1)'(ltet_pkg::PCLK_MULT);
		state_next.pclk = fsum >= (ltet_pkg::SPD_W + 1)'(ltet_pkg::SPCLK_DIV);
		state_next.frac = state_next.pclk
			? ltet_pkg::SPD_W'(fsum - (ltet_pkg::SPD_W + 1)'(ltet_pkg::SPCLK_DIV))
			: ltet_pkg::SPD_W'(fsum);
		// Mode decode
		ext = trigger_mode_command_in;
		pulse_width_exposure_mode = ext && exp_mode_command_in == ltet_pkg::EXP_PULSE;
		// Pulse width qualification
		min_w = trig_ttl_sel_in ? ltet_pkg::WID_W'(TTL_MIN_CYC)
			: ltet_pkg::WID_W'(ltet_pkg::CL_MIN_CYC);
		if (!trig)
			state_next.wid = '0;
		else if (state_reg.wid != min_w)
			state_next.wid = state_reg.wid + 1'b1;
		qualify = ext && trig && state_reg.wid == min_w - 1'b1;
		fall = state_reg.trig_d && !trig;
		state_next.short_p = ext && fall && state_reg.wid < min_w;
		// Exposure targets in sensor clocks
		period = ltet_clamp(line_period_in, ltet_pkg::MIN_PER_SP,
			ltet_pkg::MAX_PER_SP);
		off_t = ext ? state_reg.meas : period;
		off_t = ltet_clamp(ltet_sub(off_t, ltet_pkg::OVH_SP),
			ltet_pkg::MIN_EXP_SP, ltet_pkg::MAX_PER_SP);
		lim = ext ? ltet_pkg::MAX_SH_SP
			: ltet_clamp(ltet_sub(period, ltet_pkg::OVH_SP),
				ltet_pkg::MIN_EXP_SP, ltet_pkg::MAX_SH_SP);
		if (exp_mode_command_in == ltet_pkg::EXP_TIMED) begin
			tgt1 = ltet_clamp(shutter_ch1_in, ltet_pkg::MIN_EXP_SP, lim);
			tgt2 = ltet_clamp(shutter_ch2_in, ltet_pkg::MIN_EXP_SP, lim);
		end else begin
			tgt1 = off_t;
			tgt2 = off_t;
		end
		// Period counter
		if (tick && state_reg.per != {W{1'b1}})
			state_next.per = state_reg.per + 1'b1;
		// Line start
		start = 1'b0;
		state_next.reject = 1'b0;
		if (!ext)
			start = tick && state_reg.per + 1'b1 >= period;
		else if (qualify) begin
			start = state_reg.first ||
				state_reg.per > ltet_pkg::MIN_PER_SP;
			state_next.reject = !start;
		end
		state_next.line = start;
		// Accumulation
		if (start) begin
			state_next.per = '0;
			state_next.meas = state_reg.per;
			state_next.first = 1'b0;
			state_next.acc = '0;
			state_next.acc1 = 1'b1;
			state_next.acc2 = 1'b1;
			state_next.pw_run = pulse_width_exposure_mode;
		end else if (state_reg.pw_run) begin
			if (tick)
				state_next.acc = state_reg.acc + 1'b1;
			if (!trig || (tick && state_reg.acc + 1'b1 >=
				ltet_pkg::MAX_SH_SP)) begin
				state_next.pw_run = 1'b0;
				state_next.acc1 = 1'b0;
				state_next.acc2 = 1'b0;
			end
		end else if (tick) begin
			state_next.acc = state_reg.acc + 1'b1;
			if (state_reg.acc + 1'b1 >= tgt1)
				state_next.acc1 = 1'b0;
			if (state_reg.acc + 1'b1 >= tgt2)
				state_next.acc2 = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
			state_reg.first <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign line_start_out = state_reg.line;
	assign accum_ch1_out = state_reg.acc1;
	assign accum_ch2_out = state_reg.acc2;
	assign spclk_out = state_reg.spclk;
	assign pclk_stb_out = state_reg.pclk;
	assign trig_reject_out = state_reg.reject;
	assign trig_short_out = state_reg.short_p;
	assign shutter_en_out = exp_mode_command_in != ltet_pkg::EXP_OFF;
	assign balance_gain_only_out =
		exp_mode_command_in == ltet_pkg::EXP_OFF;
	assign link.line_start = state_reg.line;
	assign link.accum_ch1 = state_reg.acc1;
	assign link.accum_ch2 = state_reg.acc2;
endmodule

// File: core/ltet_source.sv
// Source end: programmable line trigger generator
`timescale 1ns/10ps
module ltet_source #(
	parameter int MIN_PER_CYC = ltet_pkg::MIN_PER_CYC,
	parameter int TTL_MIN_CYC = ltet_pkg::TTL_MIN_CYC,
	parameter int MAX_SH_CYC  = ltet_pkg::MAX_SH_CYC,
	parameter int GAP_CYC     = ltet_pkg::GAP_CYC
) (
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	ltet_link_if.src_mp                      link,
	input  wire logic [ltet_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [ltet_pkg::DATA_W-1:0] wr_data_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	output logic      [ltet_pkg::DATA_W-1:0] rd_data_out,
	output logic                             line_discard_out
);
	localparam int H = ltet_pkg::HC_W;

	typedef struct packed {
		logic [2:0]                    ctrl;
		logic [H-1:0]                  period;
		logic [H-1:0]                  width;
		logic [H-1:0]                  expo;
		logic                          disc;
		logic [ltet_pkg::LCNT_W-1:0]   lines;
		ltet_pkg::ltet_gen_t           gen;
		logic [H-1:0]                  cnt;
		logic [H-1:0]                  gap;
		logic                          seen;
		logic [1:0]                    ls_sync;
		logic                          ls_d;
		logic                          trig;
		logic                          disc_p;
		logic [ltet_pkg::DATA_W-1:0]   rdata;
	} ltet_src_state_t;

	ltet_src_state_t state_reg;
	ltet_src_state_t state_next;

	function automatic logic [H-1:0] ltet_max(
		input logic [H-1:0] a,
		input logic [H-1:0] b
	);
		return (a > b) ? a : b;
	endfunction

	logic [H-1:0] w_eff;
	logic [H-1:0] p_eff;
	logic         ls;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		state_next.disc_p = 1'b0;
		// Width floor per input, ceiling in pulse mode
		w_eff = ltet_max(state_reg.width, state_reg.ctrl[ltet_pkg::CTRL_TTL]
			? H'(TTL_MIN_CYC) : H'(ltet_pkg::CL_MIN_CYC));
		if (state_reg.ctrl[ltet_pkg::CTRL_PULSE] && w_eff > H'(MAX_SH_CYC))
			w_eff = H'(MAX_SH_CYC);
		p_eff = ltet_max(state_reg.period, H'(MIN_PER_CYC));
		p_eff = ltet_max(p_eff, state_reg.expo + H'(ltet_pkg::OVH_CYC));
		p_eff = ltet_max(p_eff, w_eff + 1'b1);
		// Generator runs without pause while enabled
		unique case (state_reg.gen)
			ltet_pkg::LTET_IDLE: begin
				state_next.cnt = '0;
				if (state_reg.ctrl[ltet_pkg::CTRL_RUN])
					state_next.gen = ltet_pkg::LTET_HIGH;
			end
			ltet_pkg::LTET_HIGH: begin
				state_next.cnt = state_reg.cnt + 1'b1;
				if (state_reg.cnt + 1'b1 >= w_eff)
					state_next.gen = ltet_pkg::LTET_LOW;
			end
			ltet_pkg::LTET_LOW: begin
				state_next.cnt = state_reg.cnt + 1'b1;
				if (state_reg.cnt + 1'b1 >= p_eff) begin
					state_next.cnt = '0;
					state_next.gen = state_reg.ctrl[ltet_pkg::CTRL_RUN]
						? ltet_pkg::LTET_HIGH : ltet_pkg::LTET_IDLE;
				end
			end
		endcase
		state_next.trig = state_next.gen == ltet_pkg::LTET_HIGH;
		// Discard first line and lines after long gaps
		state_next.ls_sync = {state_reg.ls_sync[0], link.line_start};
		ls = state_reg.ls_sync[1];
		state_next.ls_d = ls;
		if (state_reg.gap != {H{1'b1}})
			state_next.gap = state_reg.gap + 1'b1;
		if (ls && !state_reg.ls_d) begin
			state_next.gap = '0;
			state_next.seen = 1'b1;
			state_next.lines = state_reg.lines + 1'b1;
			state_next.disc_p = !state_reg.seen ||
				state_reg.gap >= H'(GAP_CYC);
		end
		// Register writes
		if (wr_in) begin
			unique case (addr_in)
				ltet_pkg::REG_CTRL:   state_next.ctrl = wr_data_in[2:0];
				ltet_pkg::REG_PERIOD: state_next.period = wr_data_in[H-1:0];
				ltet_pkg::REG_WIDTH:  state_next.width = wr_data_in[H-1:0];
				ltet_pkg::REG_EXPO:   state_next.expo = wr_data_in[H-1:0];
				ltet_pkg::REG_STATUS:
					if (wr_data_in[ltet_pkg::STAT_DISC])
						state_next.disc = 1'b0;
				default: ;
			endcase
		end
		if (state_next.disc_p)
			state_next.disc = 1'b1;
		// Register reads
		state_next.rdata = '0;
		if (rd_in) begin
			unique case (addr_in)
				ltet_pkg::REG_CTRL:   state_next.rdata[2:0] = state_reg.ctrl;
				ltet_pkg::REG_PERIOD: state_next.rdata[H-1:0] = state_reg.period;
				ltet_pkg::REG_WIDTH:  state_next.rdata[H-1:0] = state_reg.width;
				ltet_pkg::REG_EXPO:   state_next.rdata[H-1:0] = state_reg.expo;
				ltet_pkg::REG_STATUS: begin
					state_next.rdata[ltet_pkg::STAT_DISC] = state_reg.disc;
					state_next.rdata[ltet_pkg::STAT_RUN] =
						state_reg.gen != ltet_pkg::LTET_IDLE;
					state_next.rdata[ltet_pkg::LCNT_LSB +: ltet_pkg::LCNT_W] =
						state_reg.lines;
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign rd_data_out = state_reg.rdata;
	assign line_discard_out = state_reg.disc_p;
	assign link.trig_cl = state_reg.trig & ~state_reg.ctrl[ltet_pkg::CTRL_TTL];
	assign link.trig_ttl = state_reg.trig & state_reg.ctrl[ltet_pkg::CTRL_TTL];
endmodule

// File: dv/line_trigger_exposure_timing_test.sv
// Self-checking bench for both ends of the line trigger link
`timescale 1ns/10ps
module line_trigger_exposure_timing_test;
	localparam int TM = 40;
	logic        clk_in   = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [1:0]  emode    = 2'h0;
	logic        tmode    = 1'b0;
	logic        tsel     = 1'b0;
	logic        t2       = 1'b0;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic [7:0]  addr     = 8'h00;
	logic [13:0] lper     = 14'h00B4;
	logic [13:0] sh1      = 14'h0088;
	logic [13:0] sh2      = 14'h0088;
	logic [31:0] wd       = 32'h0000_0000;
	logic [31:0] rdd;
	logic [31:0] v;
	logic        ls, a1, a2, pk, sp, sp_q, sen, bal, disc, ls2, rej, sho;
	int          errors   = 0;
	int          checked  = 0;
	int          cyc      = 0;
	int          n_ls, n_disc, n_rej, n_sho, n_ls2, n_pk, n_sp, p, q, s, e1, e2;
	int          xp;
	logic [7:0]  regs [6] = '{ltet_pkg::REG_CTRL, ltet_pkg::REG_PERIOD,
		ltet_pkg::REG_WIDTH, ltet_pkg::REG_EXPO, ltet_pkg::REG_STATUS, 8'h14};
	ltet_link_if lk ();
	ltet_link_if lk2 ();
	assign lk2.trig_cl  = t2;
	assign lk2.trig_ttl = 1'b0;
	always #2.5 clk_in = ~clk_in;
	ltet_source #(.MIN_PER_CYC(200), .TTL_MIN_CYC(TM), .MAX_SH_CYC(500),
		.GAP_CYC(20000)) u_ltet_source (.clk_in, .rst_n_in, .link(lk),
		.addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd),
		.rd_data_out(rdd), .line_discard_out(disc));
	ltet_sensor #(.TTL_MIN_CYC(TM)) u_ltet_sensor (.clk_in, .rst_n_in,
		.link(lk), .exp_mode_command_in(emode),
		.trigger_mode_command_in(tmode), .trig_ttl_sel_in(tsel),
		.line_period_in(lper), .shutter_ch1_in(sh1), .shutter_ch2_in(sh2),
		.line_start_out(ls), .accum_ch1_out(a1), .accum_ch2_out(a2),
		.spclk_out(sp), .pclk_stb_out(pk), .shutter_en_out(sen),
		.balance_gain_only_out(bal), .trig_reject_out(), .trig_short_out());
	ltet_sensor #(.TTL_MIN_CYC(TM)) u_ltet_sensor_b (.clk_in, .rst_n_in,
		.link(lk2), .exp_mode_command_in(emode),
		.trigger_mode_command_in(tmode), .trig_ttl_sel_in(tsel),
		.line_period_in(lper), .shutter_ch1_in(sh1), .shutter_ch2_in(sh2),
		.line_start_out(ls2), .accum_ch1_out(), .accum_ch2_out(),
		.spclk_out(), .pclk_stb_out(), .shutter_en_out(),
		.balance_gain_only_out(), .trig_reject_out(rej), .trig_short_out(sho));
	ltet_link_assertions #(.TTL_MIN_CYC(TM), .MIN_PER_CYC(200))
		u_ltet_link_assertions (.clk_in, .rst_n_in, .trig_cl(lk.trig_cl),
		.trig_ttl(lk.trig_ttl), .line_start(lk.line_start),
		.accum_ch1(lk.accum_ch1), .accum_ch2(lk.accum_ch2));
	// ****************
	// Event counters and watchdog
	// ****************
	always @(negedge clk_in) begin
		cyc++;
		n_ls += ls;
		n_disc += disc;
		n_rej += rej;
		n_sho += sho;
		n_ls2 += ls2;
		n_pk += pk;
		n_sp += sp & ~sp_q;
		sp_q = sp;
		if (cyc == 90000) begin
			errors++;
			results();
		end
	end
	// ****************
	// Tasks
	// ****************
	task automatic results;
		if (errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	function automatic int exp_per(input int pr, input int ex);
		return (pr > ex + ltet_pkg::OVH_CYC) ? pr : ex + ltet_pkg::OVH_CYC;
	endfunction
	task automatic cv(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cn(input string nm, input int e, input int g, input int t);
		checked++;
		if (g < e - t || g > e + t) begin
			errors++;
			$display("BAD %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		d = rdd;
	endtask
	task automatic go(input logic [1:0] m, input logic t, input logic sl,
		input logic [13:0] pr, input logic [13:0] s1, input logic [13:0] s2);
		@(posedge clk_in);
		emode <= m;
		tmode <= t;
		tsel <= sl;
		lper <= pr;
		sh1 <= s1;
		sh2 <= s2;
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		n_ls = 0;
		n_disc = 0;
		n_rej = 0;
		n_sho = 0;
		n_ls2 = 0;
	endtask
	task automatic wait_ls;
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (ls !== 1'b1 && n < 30000);
	endtask
	task automatic meas(output int pr, output int x1, output int x2);
		pr = 0;
		x1 = 1;
		x2 = 1;
		do begin
			@(posedge clk_in);
			#1;
			pr++;
			x1 += (a1 === 1'b1);
			x2 += (a2 === 1'b1);
		end while (ls !== 1'b1 && pr < 30000);
	endtask
	task automatic tpulse(input int hi, input int lo);
		@(posedge clk_in);
		t2 <= 1'b1;
		repeat (hi) @(posedge clk_in);
		t2 <= 1'b0;
		repeat (lo) @(posedge clk_in);
	endtask
	// ****************
	// Scenarios
	// ****************
	initial begin
		void'($urandom(32'hcc6a9cc7));
		go(ltet_pkg::EXP_OFF, 1'b0, 1'b0, 14'h00B4, 14'h0088, 14'h0088);
		foreach (regs[i]) begin
			rd_reg(regs[i], v);
			cv("reg", 32'h0000_0000, v);
		end
		q = $urandom_range(5600, 5200);
		wr_reg(ltet_pkg::REG_PERIOD, 32'(q));
		wr_reg(8'h14, 32'(q));
		rd_reg(ltet_pkg::REG_PERIOD, v);
		cv("period", 32'(q), v);
		rd_reg(8'h14, v);
		cv("unmapped", 32'h0000_0000, v);
		p = $urandom_range(190, 171);
		go(ltet_pkg::EXP_OFF, 1'b0, 1'b0, 14'(p), 14'h0088, 14'h0088);
		cv("shutter_en", 32'h0000_0000, 32'(sen));
		cv("gain_only", 32'h0000_0001, 32'(bal));
		wait_ls();
		meas(q, e1, e2);
		cn("line_period", p * 30, q, 0);
		cn("exposure", (p - 35) * 30, e1, 30);
		n_pk = 0;
		n_sp = 0;
		repeat (300) @(posedge clk_in);
		cn("pclk", 80, n_pk, 0);
		cn("spclk", 10, n_sp, 0);
		p = $urandom_range(190, 171);
		go(ltet_pkg::EXP_TIMED, 1'b0, 1'b0, 14'(p), 14'h0088, 14'(p));
		cv("shutter_en", 32'h0000_0001, 32'(sen));
		wait_ls();
		meas(q, e1, e2);
		cn("exposure1", 136 * 30, e1, 30);
		cn("exposure2", (p - 35) * 30, e2, 30);
		p = $urandom_range(5600, 5200);
		go(ltet_pkg::EXP_OFF, 1'b1, 1'b0, 14'h00B4, 14'h0088, 14'h0088);
		wr_reg(ltet_pkg::REG_PERIOD, 32'(p));
		wr_reg(ltet_pkg::REG_CTRL, 32'h0000_0001);
		wait_ls();
		meas(q, e1, e2);
		meas(q, e1, e2);
		cn("trig_period", p, q, 0);
		cn("exposure", (p / 30 - 35) * 30, e1, 60);
		repeat (3) @(posedge clk_in);
		rd_reg(ltet_pkg::REG_STATUS, v);
		cv("status", {16'(n_ls), 16'h0003}, v);
		wr_reg(ltet_pkg::REG_STATUS, 32'h0000_0001);
		rd_reg(ltet_pkg::REG_STATUS, v);
		cv("discard", 32'h0000_0000, {31'h0, v[0]});
		cn("discards", 1, n_disc, 0);
		p = $urandom_range(150, 136);
		s = $urandom_range(150, 136);
		go(ltet_pkg::EXP_TIMED, 1'b1, 1'b1, 14'h00B4, 14'(p), 14'(s));
		wr_reg(ltet_pkg::REG_PERIOD, 32'h0000_1518);
		wr_reg(ltet_pkg::REG_WIDTH, 32'h0000_0064);
		xp = ((p > s) ? p : s) * 30;
		wr_reg(ltet_pkg::REG_EXPO, 32'(xp));
		xp = exp_per(5400, xp);
		wr_reg(ltet_pkg::REG_CTRL, 32'h0000_0003);
		wait_ls();
		meas(q, e1, e2);
		cn("trig_period", xp, q, 0);
		cn("exposure1", p * 30, e1, 30);
		cn("exposure2", s * 30, e2, 30);
		p = $urandom_range(450, 250);
		go(ltet_pkg::EXP_PULSE, 1'b1, 1'b1, 14'h00B4, 14'h0088, 14'h0088);
		wr_reg(ltet_pkg::REG_PERIOD, 32'h0000_1518);
		wr_reg(ltet_pkg::REG_WIDTH, 32'(p));
		wr_reg(ltet_pkg::REG_CTRL, 32'h0000_0007);
		wait_ls();
		meas(q, e1, e2);
		cn("pulse_exposure", p - TM, e1, 30);
		cn("trig_period", 5400, q, 0);
		go(ltet_pkg::EXP_OFF, 1'b1, 1'b0, 14'h00B4, 14'h0088, 14'h0088);
		tpulse(100, 100);
		tpulse(4200, 100);
		tpulse(4200, 200);
		cn("short", 1, n_sho, 0);
		cn("lines", 1, n_ls2, 0);
		cn("reject", 1, n_rej, 0);
		results();
	end
endmodule

// File: dv/ltet_link_assertions.sv
// Concurrent checks on the trigger and line timing link
`timescale 1ns/10ps
module ltet_link_assertions #(
	parameter int TTL_MIN_CYC = 40,
	parameter int MIN_PER_CYC = 200
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic trig_cl,
	input wire logic trig_ttl,
	input wire logic line_start,
	input wire logic accum_ch1,
	input wire logic accum_ch2
);
	localparam logic [19:0] SAT     = 20'hF_FFFF;
	localparam logic [19:0] MIN_LS  = 20'h0_13EC;
	localparam logic [19:0] MIN_GAP = 20'h0_03E8;
	localparam logic [19:0] CL_MIN  = 20'h0_1000;
	localparam logic [19:0] ACC_MAX = 20'h6_1788;
	logic [19:0] cl_reg;
	logic [19:0] ttl_reg;
	logic [19:0] rise_reg;
	logic [19:0] ls_reg;
	logic [19:0] gap_reg;
	logic [19:0] acc_reg;
	function automatic logic [19:0] inc(input logic [19:0] v);
		return (v == SAT) ? v : v + 20'h0_0001;
	endfunction
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ****************
	// Run counters
	// ****************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cl_reg   <= '0;
			ttl_reg  <= '0;
			rise_reg <= SAT;
			ls_reg   <= SAT;
			gap_reg  <= SAT;
			acc_reg  <= '0;
		end else begin
			cl_reg   <= trig_cl ? inc(cl_reg) : '0;
			ttl_reg  <= trig_ttl ? inc(ttl_reg) : '0;
			rise_reg <= ($rose(trig_cl) || $rose(trig_ttl)) ? 20'h0_0001
				: inc(rise_reg);
			ls_reg   <= line_start ? 20'h0_0001 : inc(ls_reg);
			gap_reg  <= accum_ch1 ? '0 : inc(gap_reg);
			acc_reg  <= accum_ch1 ? inc(acc_reg) : '0;
		end
	end
	// ****************
	// Properties
	// ****************
	AST_LS_ONE: assert property (line_start |=> !line_start)
		else $error("line start longer than one cycle");
	AST_LS_ACCUM: assert property (line_start |-> accum_ch1 && accum_ch2)
		else $error("line start without accumulation");
	AST_ACC_RISE: assert property (($rose(accum_ch1) || $rose(accum_ch2))
		|-> line_start)
		else $error("accumulation began away from line start");
	AST_LS_SPACE: assert property (line_start |-> ls_reg >= MIN_LS)
		else $error("line starts too close");
	AST_ACC_GAP: assert property (line_start |-> gap_reg >= MIN_GAP)
		else $error("exposure overhead too short");
	AST_ACC_MAX: assert property (accum_ch1 |-> acc_reg < ACC_MAX)
		else $error("accumulation too long");
	AST_CL_WIDTH: assert property ($fell(trig_cl) |-> cl_reg >= CL_MIN)
		else $error("link trigger pulse too short");
	AST_TTL_WIDTH: assert property ($fell(trig_ttl)
		|-> ttl_reg >= 20'(TTL_MIN_CYC))
		else $error("ttl trigger pulse too short");
	AST_TRIG_PER: assert property (($rose(trig_cl) || $rose(trig_ttl))
		|-> rise_reg >= 20'(MIN_PER_CYC))
		else $error("triggers too close");
	cover property (line_start && accum_ch1);
	cover property ($fell(trig_cl));
	cover property ($fell(trig_ttl));
endmodule
